// ---- rtl/rfc_pkg.sv ----
// package: register map, field positions, reset values and timing for the rtc flags block
package rfc_pkg;

  localparam int unsigned ADDR_W = 19;

  // flags register keeps its byte-wide index; the word bus sees four bytes per index
  localparam int unsigned FLAGS_IDX = 32'h0001_fff0;

  // register byte addresses
  localparam logic [ADDR_W-1:0] FLAGS_OFF    = ADDR_W'(FLAGS_IDX << 2);
  localparam logic [ADDR_W-1:0] TIME_OFF     = 19'h20000;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 19'h20004;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 19'h20008;

  // flags register fields
  localparam int unsigned FLD_WDOG   = 7;
  localparam int unsigned FLD_ALARM  = 6;
  localparam int unsigned FLD_PFAIL  = 5;
  localparam int unsigned FLD_OSC    = 4;
  localparam int unsigned FLD_CAL    = 2;
  localparam int unsigned FLD_FREEZE = 1;
  localparam int unsigned FLD_SNAP   = 0;

  // interrupt status / mask fields
  localparam int unsigned IRQ_WDOG  = 0;
  localparam int unsigned IRQ_ALARM = 1;
  localparam int unsigned IRQ_PFAIL = 2;
  localparam int unsigned IRQ_OSC   = 3;
  localparam int unsigned IRQ_N     = 4;

  localparam logic [7:0]  FLAGS_RST    = 8'h00;
  localparam logic [31:0] TIME_RST     = 32'h0000_0000;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // timing
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned CAL_HZ       = 512;
  localparam int unsigned OSC_CHECK_MS = 5;
  localparam int unsigned CAL_HALF_CYC = CLK_HZ / (2 * CAL_HZ);
  localparam int unsigned OSC_CHECK_CYC = (CLK_HZ / 1000) * OSC_CHECK_MS;
  localparam int unsigned SEC_CYC      = CLK_HZ;

  typedef struct packed {
    logic wdog;
    logic alarm;
    logic pfail;
    logic osc;
    logic zero;
    logic cal;
    logic wfreeze;
    logic rsnap;
  } rfc_flags_s;

  typedef enum logic [2:0] {
    SEL_FLAGS,
    SEL_TIME,
    SEL_STAT,
    SEL_MASK,
    SEL_NONE
  } rfc_sel_e;

  typedef enum logic [1:0] {
    OSC_LOAD,
    OSC_WATCH,
    OSC_DONE
  } rfc_osc_e;

endpackage : rfc_pkg

// ---- rtl/rfc_tick_div.sv ----
// tick divider: one-cycle enable pulse every DIV clock cycles
`timescale 1ns/1ps
`default_nettype none
module rfc_tick_div #(
  parameter int unsigned DIV = 2
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clr,
  output logic      tick
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + CW'(1);
    if (clr) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule // rfc_tick_div
`default_nettype wire

// ---- rtl/rfc_flags_ctrl.sv ----
// rtc flags and control register with axi4-lite slave, interrupt logic and time image
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rfc_flags_ctrl
  import rfc_pkg::*;
#(
  parameter int unsigned CAL_HALF = CAL_HALF_CYC,
  parameter int unsigned OSC_WAIT = OSC_CHECK_CYC,
  parameter int unsigned SEC_DIV  = SEC_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              watchdog_expired,
  input  wire logic              alarm_match,
  input  wire logic              power_fail_threshold,
  input  wire logic              osc_running,
  input  wire logic              osc_flag_retained_in,
  output logic                   osc_flag_retained_out,
  output logic [31:0]            time_count,
  output logic                   int_out
);

  function automatic rfc_sel_e decode(input logic [ADDR_W-1:0] a);
    unique case (a)
      FLAGS_OFF:    decode = SEL_FLAGS;
      TIME_OFF:     decode = SEL_TIME;
      IRQ_STAT_OFF: decode = SEL_STAT;
      IRQ_MASK_OFF: decode = SEL_MASK;
      default:      decode = SEL_NONE;
    endcase
  endfunction

  localparam int unsigned OW = $clog2(OSC_WAIT + 1);
  localparam logic [OW-1:0] OSC_LAST = OW'(OSC_WAIT - 1);

  // axi state
  logic              awready_q, awready_d, wready_q, wready_d;
  logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0]       w_data_q, w_data_d;
  logic [3:0]        w_strb_q, w_strb_d;
  logic              bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  // block state
  rfc_flags_s        flags_q, flags_d;
  logic [31:0]       time_cnt_q, time_cnt_d, time_reg_q, time_reg_d, snap_q, snap_d;
  logic [IRQ_N-1:0]  stat_q, stat_d, mask_q, mask_d;
  logic              int_q, int_d, wave_q, wave_d;
  rfc_osc_e          osc_st_q, osc_st_d;
  logic [OW-1:0]     osc_cnt_q, osc_cnt_d;
  logic              osc_seen_q, osc_seen_d;
  // strobes
  logic              wr_fire, ar_fire, rd_flags, osc_set;
  rfc_sel_e          wr_sel, rd_sel;
  logic              cal_tick, sec_tick;

  rfc_tick_div #(.DIV(CAL_HALF)) u_cal_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (!flags_q.cal),
    .tick    (cal_tick)
  );

  rfc_tick_div #(.DIV(SEC_DIV)) u_sec_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (flags_q.wfreeze),
    .tick    (sec_tick)
  );

  always_comb begin
    wr_fire  = aw_have_q && w_have_q && !bvalid_q;
    ar_fire  = arvalid && arready_q;
    wr_sel   = decode(aw_addr_q);
    rd_sel   = decode(araddr);
    rd_flags = ar_fire && (rd_sel == SEL_FLAGS);
    osc_set  = 1'b0;
    // write channel: address and data taken in either order
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
    // read channel
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (rd_sel)
        SEL_FLAGS: rdata_d = {24'h000000, flags_q};
        SEL_TIME:  rdata_d = flags_q.rsnap ? snap_q : time_reg_q;
        SEL_STAT:  rdata_d = {28'h0000000, stat_q};
        SEL_MASK:  rdata_d = {28'h0000000, mask_q};
        SEL_NONE: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_DECERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
    // oscillator check after power up; the flag itself lives in retained storage
    osc_st_d   = osc_st_q;
    osc_cnt_d  = osc_cnt_q;
    osc_seen_d = osc_seen_q | osc_running;
    flags_d    = flags_q;
    unique case (osc_st_q)
      OSC_LOAD: begin
        flags_d.osc = osc_flag_retained_in;
        osc_st_d    = OSC_WATCH;
        osc_cnt_d   = '0;
        osc_seen_d  = 1'b0;
      end
      OSC_WATCH: begin
        osc_cnt_d = osc_cnt_q + OW'(1);
        if (osc_cnt_q == OSC_LAST) begin
          osc_st_d = OSC_DONE;
          osc_set  = !(osc_seen_q || osc_running);
        end
      end
      OSC_DONE: begin
        osc_cnt_d = osc_cnt_q;
      end
    endcase
    // wdog, alarm and pfail flags: read clears, a coincident event wins
    flags_d.wdog  = (flags_q.wdog && !rd_flags) || watchdog_expired;
    flags_d.alarm = (flags_q.alarm && !rd_flags) || alarm_match;
    flags_d.pfail = (flags_q.pfail && !rd_flags) || power_fail_threshold;
    flags_d.zero  = 1'b0;
    if (wr_fire && wr_sel == SEL_FLAGS && w_strb_q[0]) begin
      flags_d.cal     = w_data_q[FLD_CAL];
      flags_d.wfreeze = w_data_q[FLD_FREEZE];
      flags_d.rsnap   = w_data_q[FLD_SNAP];
      if (!w_data_q[FLD_OSC]) begin
        flags_d.osc = 1'b0;
      end
    end
    if (osc_set) begin
      flags_d.osc = 1'b1;
    end
    // time: counter runs and visible image follows, both only while not frozen
    time_cnt_d = sec_tick ? time_cnt_q + 32'h0000_0001 : time_cnt_q;
    time_reg_d = flags_q.wfreeze ? time_reg_q : time_cnt_q;
    if (flags_q.wfreeze && wr_fire && wr_sel == SEL_TIME) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb_q[i]) begin
          time_reg_d[8*i +: 8] = w_data_q[8*i +: 8];
        end
      end
    end
    if (flags_q.wfreeze && !flags_d.wfreeze) begin
      time_cnt_d = time_reg_q;
    end
    snap_d = (flags_d.rsnap && !flags_q.rsnap) ? time_reg_q : snap_q;
    // sticky interrupt status, write one to clear, set wins
    stat_d = stat_q;
    if (wr_fire && wr_sel == SEL_STAT && w_strb_q[0]) begin
      stat_d = stat_q & ~w_data_q[IRQ_N-1:0];
    end
    stat_d[IRQ_WDOG]  = stat_d[IRQ_WDOG] | watchdog_expired;
    stat_d[IRQ_ALARM] = stat_d[IRQ_ALARM] | alarm_match;
    stat_d[IRQ_PFAIL] = stat_d[IRQ_PFAIL] | power_fail_threshold;
    stat_d[IRQ_OSC]   = stat_d[IRQ_OSC] | osc_set;
    mask_d = mask_q;
    if (wr_fire && wr_sel == SEL_MASK && w_strb_q[0]) begin
      mask_d = w_data_q[IRQ_N-1:0];
    end
    // calibration overrides the interrupt pin with the square wave
    wave_d = !flags_q.cal ? 1'b0 : (cal_tick ? !wave_q : wave_q);
    int_d  = flags_q.cal ? wave_q : |(stat_q & mask_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      aw_addr_q  <= '0;
      w_data_q   <= 32'h0000_0000;
      w_strb_q   <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= RESP_OKAY;
      flags_q    <= FLAGS_RST;
      time_cnt_q <= TIME_RST;
      time_reg_q <= TIME_RST;
      snap_q     <= TIME_RST;
      stat_q     <= '0;
      mask_q     <= IRQ_MASK_RST;
      int_q      <= 1'b0;
      wave_q     <= 1'b0;
      osc_st_q   <= OSC_LOAD;
      osc_cnt_q  <= '0;
      osc_seen_q <= 1'b0;
    end else begin
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      aw_addr_q  <= aw_addr_d;
      w_data_q   <= w_data_d;
      w_strb_q   <= w_strb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      flags_q    <= flags_d;
      time_cnt_q <= time_cnt_d;
      time_reg_q <= time_reg_d;
      snap_q     <= snap_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      int_q      <= int_d;
      wave_q     <= wave_d;
      osc_st_q   <= osc_st_d;
      osc_cnt_q  <= osc_cnt_d;
      osc_seen_q <= osc_seen_d;
    end
  end

  assign awready               = awready_q;
  assign wready                = wready_q;
  assign bvalid                = bvalid_q;
  assign bresp                 = bresp_q;
  assign arready               = arready_q;
  assign rvalid                = rvalid_q;
  assign rdata                 = rdata_q;
  assign rresp                 = rresp_q;
  assign osc_flag_retained_out = flags_q.osc;
  assign time_count            = time_cnt_q;
  assign int_out               = int_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_flags_read;
    ar_fire && rd_sel == SEL_FLAGS;
  endsequence

  sequence s_quiet_events;
    !watchdog_expired && !alarm_match && !power_fail_threshold;
  endsequence

  a_wdog_flag_set: assert property (watchdog_expired |=> flags_q.wdog)
    else $error("watchdog flag not set after expiry");
  a_alarm_flag_set: assert property (alarm_match |=> flags_q.alarm)
    else $error("alarm flag not set after match");
  a_pfail_flag_set: assert property (power_fail_threshold |=> flags_q.pfail)
    else $error("power fail flag not set");
  a_read_clears_flags: assert property (
      (s_flags_read and s_quiet_events) |=> !flags_q.wdog && !flags_q.alarm && !flags_q.pfail)
    else $error("flags read did not clear event flags");
  a_osc_flag_set: assert property (
      osc_st_q == OSC_WATCH && osc_cnt_q == OSC_LAST && !osc_seen_q && !osc_running
      |=> flags_q.osc && osc_st_q == OSC_DONE)
    else $error("oscillator flag not set after silent check window");
  a_osc_flag_hold: assert property (
      flags_q.osc && osc_st_q != OSC_LOAD
      && !(wr_fire && wr_sel == SEL_FLAGS && w_strb_q[0] && !w_data_q[FLD_OSC])
      |=> flags_q.osc)
    else $error("oscillator flag cleared without software");
  a_osc_retained: assert property (osc_st_q == OSC_LOAD |=> flags_q.osc == $past(osc_flag_retained_in))
    else $error("retained oscillator flag not restored");
  a_cal_wave: assert property (flags_q.cal && $past(flags_q.cal) |=> int_out == $past(wave_q))
    else $error("calibration wave not on interrupt output");
  a_cal_power_up: assert property ($rose(aresetn) |-> !flags_q.cal)
    else $error("calibration bit not cleared at power up");
  a_freeze_hold: assert property (
      flags_q.wfreeze && !(wr_fire && wr_sel == SEL_TIME) |=> $stable(time_reg_q))
    else $error("time image changed while frozen");
  a_freeze_load: assert property ($fell(flags_q.wfreeze) |-> time_cnt_q == $past(time_reg_q))
    else $error("counters not loaded from time image");
  a_time_write: assert property (
      flags_q.wfreeze && wr_fire && wr_sel == SEL_TIME && w_strb_q == 4'hf
      |=> time_reg_q == $past(w_data_q))
    else $error("time write lost while frozen");
  a_snap_static: assert property (flags_q.rsnap && $past(flags_q.rsnap) |-> $stable(snap_q))
    else $error("snapshot image moved");
  a_event_wins: assert property (s_flags_read ##0 watchdog_expired |=> flags_q.wdog)
    else $error("event lost to read clear");

endmodule // rfc_flags_ctrl
`default_nettype wire

// ---- tb/rfc_event_side.sv ----
// far-side model: oscillator source and retained storage of the oscillator flag
`timescale 1ns/1ps
`default_nettype none
module rfc_event_side (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic osc_stop,
  input  wire logic osc_flag_retained_out,
  output logic      osc_running,
  output logic      osc_flag_retained_in
);
  logic [1:0] up_q = 2'h0;
  logic       store_q = 1'b0;
  // no reset on the store: it must outlive power cycles
  always_ff @(posedge aclk) begin
    up_q <= !aresetn ? 2'h0 : (up_q == 2'h3) ? up_q : up_q + 2'h1;
    // wait until the block has reloaded its flag, or the store loses it
    if (aresetn && up_q == 2'h3) begin
      store_q <= osc_flag_retained_out;
    end
  end
  assign osc_running          = ~osc_stop;
  assign osc_flag_retained_in = store_q;
endmodule // rfc_event_side
`default_nettype wire

// ---- tb/test_rfc_flags_ctrl.sv ----
// testbench: register bus tasks and scenarios for the rtc flags block
`timescale 1ns/1ps
`default_nettype none
module test_rfc_flags_ctrl;
  import rfc_pkg::*;
  localparam int unsigned CALH  = 4;
  localparam int unsigned OSCW  = 8;
  localparam int unsigned SECD  = 10;
  localparam int unsigned LIMIT = 20000;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = 4'hf;
  logic [2:0]        ev = 3'h0;
  logic              osc_stop = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata, time_count, rd_val, last_resp;
  logic              osc_run, ret_in, ret_out, int_out;
  int                fail_count = 0;
  int                n_checks = 0;
  int                cyc = 0;

  always #20 aclk = ~aclk;

  rfc_flags_ctrl #(.CAL_HALF(CALH), .OSC_WAIT(OSCW), .SEC_DIV(SECD)) u_rfc_flags_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .watchdog_expired(ev[2]), .alarm_match(ev[1]), .power_fail_threshold(ev[0]),
    .osc_running(osc_run), .osc_flag_retained_in(ret_in),
    .osc_flag_retained_out(ret_out), .time_count(time_count), .int_out(int_out)
  );

  rfc_event_side u_rfc_event_side (
    .aclk(aclk), .aresetn(aresetn), .osc_stop(osc_stop),
    .osc_flag_retained_out(ret_out), .osc_running(osc_run),
    .osc_flag_retained_in(ret_in)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic power_up();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (OSCW + 6) @(posedge aclk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    last_resp = {30'h0, bresp};
    bready <= 1'b0;
  endtask

  // ev_in is held for the cycle the address is offered, to hit the read edge
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [2:0] ev_in);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    ev      <= ev_in;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    ev      <= 3'h0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_val    = rdata;
    last_resp = {30'h0, rresp};
    rready   <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    rd(a, 3'h0);
    check(what, rd_val, exp);
  endtask

  task automatic pulse(input logic [2:0] e);
    @(posedge aclk);
    ev <= e;
    @(posedge aclk);
    ev <= 3'h0;
  endtask

  initial begin
    logic [31:0] t0;
    int          n;
    power_up();
    rd_chk("flags rst", FLAGS_OFF, {24'h0, FLAGS_RST});
    rd_chk("mask rst", IRQ_MASK_OFF, {28'h0, IRQ_MASK_RST});
    check("rresp ok", last_resp, {30'h0, RESP_OKAY});
    for (int i = 0; i < 3; i++) begin
      pulse(3'h4 >> i);
      rd_chk("flag set", FLAGS_OFF, 32'h80 >> i);
      rd_chk("flag rd clr", FLAGS_OFF, 32'h0);
      rd_chk("stat set", IRQ_STAT_OFF, 32'h1 << i);
      wr(IRQ_STAT_OFF, 32'h1 << i);
      rd_chk("stat w1c", IRQ_STAT_OFF, 32'h0);
    end
    rd(FLAGS_OFF, 3'h7);
    check("flags old", rd_val, 32'h0);
    rd_chk("flags kept", FLAGS_OFF, 32'he0);
    wr(IRQ_STAT_OFF, 32'hf);
    $display("test events done");
    wr(IRQ_MASK_OFF, 32'h1);
    check("bresp ok", last_resp, {30'h0, RESP_OKAY});
    pulse(3'h4);
    repeat (3) @(posedge aclk);
    check("int up", {31'h0, int_out}, 32'h1);
    wr(IRQ_MASK_OFF, 32'h2);
    repeat (3) @(posedge aclk);
    check("int masked", {31'h0, int_out}, 32'h0);
    wr(IRQ_MASK_OFF, 32'h1);
    wr(IRQ_STAT_OFF, 32'h1);
    repeat (3) @(posedge aclk);
    check("int clr", {31'h0, int_out}, 32'h0);
    rd(FLAGS_OFF, 3'h0);
    wr(FLAGS_OFF, 32'h4);
    while (int_out !== 1'b0) @(posedge aclk);
    while (int_out !== 1'b1) @(posedge aclk);
    n = 0;
    while (int_out === 1'b1) begin
      @(posedge aclk);
      n++;
    end
    check("cal half", 32'(n), CALH);
    rd_chk("cal bit", FLAGS_OFF, 32'h4);
    wr(FLAGS_OFF, 32'h0);
    repeat (3) @(posedge aclk);
    check("cal off", {31'h0, int_out}, 32'h0);
    rd_chk("unmapped rd", 19'h00100, 32'h0);
    check("rresp", last_resp, {30'h0, RESP_DECERR});
    wr(19'h00104, 32'hffff_ffff);
    check("bresp", last_resp, {30'h0, RESP_DECERR});
    $display("test irq done");
    wr(TIME_OFF, 32'hab00_0000);
    rd(TIME_OFF, 3'h0);
    check("time wr ignored", {31'h0, rd_val < 32'h100}, 32'h1);
    wr(FLAGS_OFF, 32'h2);
    rd(TIME_OFF, 3'h0);
    t0 = rd_val;
    repeat (3 * SECD) @(posedge aclk);
    rd_chk("time frozen", TIME_OFF, t0);
    wr(TIME_OFF, 32'h0000_1000);
    rd_chk("time wr", TIME_OFF, 32'h1000);
    @(posedge aclk);
    wstrb <= 4'h1;
    wr(TIME_OFF, 32'hffff_ff22);
    wstrb <= 4'hf;
    rd_chk("time strb", TIME_OFF, 32'h1022);
    wr(FLAGS_OFF, 32'h0);
    check("cnt load", {31'h0, (time_count - 32'h1022) < 32'h2}, 32'h1);
    wr(FLAGS_OFF, 32'h1);
    rd(TIME_OFF, 3'h0);
    t0 = rd_val;
    repeat (3 * SECD) @(posedge aclk);
    rd_chk("snapshot", TIME_OFF, t0);
    check("cnt runs", {31'h0, time_count != t0}, 32'h1);
    wr(FLAGS_OFF, 32'h0);
    $display("test time done");
    @(posedge aclk);
    osc_stop <= 1'b1;
    power_up();
    rd_chk("osc set", FLAGS_OFF, 32'h10);
    rd_chk("osc no rd clr", FLAGS_OFF, 32'h10);
    rd_chk("osc stat", IRQ_STAT_OFF, 32'h8);
    wr(FLAGS_OFF, 32'h14);
    rd_chk("osc wr one", FLAGS_OFF, 32'h14);
    @(posedge aclk);
    osc_stop <= 1'b0;
    power_up();
    rd_chk("osc kept", FLAGS_OFF, 32'h10);
    wr(FLAGS_OFF, 32'h0);
    rd_chk("osc clr", FLAGS_OFF, 32'h0);
    power_up();
    rd_chk("osc stays clr", FLAGS_OFF, 32'h0);
    $display("test osc done");
    final_report();
  end
endmodule // test_rfc_flags_ctrl
`default_nettype wire
